/* File: logic/ccf_pkg.sv */
package ccf_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] FLAGS_OFFSET  = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    // ----------------------------------------
    // Flag register fields
    // ----------------------------------------
    localparam int V_BIT = 7;
    localparam int H_BIT = 4;
    localparam int I_BIT = 3;
    localparam int N_BIT = 2;
    localparam int Z_BIT = 1;
    localparam int C_BIT = 0;
    localparam logic [7:0] FIXED_ONES  = 8'h60;
    localparam logic [7:0] FLAGS_RESET = 8'h68;
    localparam logic [3:0] BCD_LIMIT   = 4'h9;
    localparam logic [7:0] DAA_LOW     = 8'h06;
    localparam logic [7:0] DAA_HIGH    = 8'h60;
    localparam logic [7:0] DAA_HLIMIT  = 8'h99;
    // ----------------------------------------
    // Operation classes reported at completion
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_NONE   = 4'b0000,
        OP_ADD    = 4'b0001,
        OP_ADC    = 4'b0010,
        OP_SUB    = 4'b0011,
        OP_SBC    = 4'b0100,
        OP_LOGIC  = 4'b0101,
        OP_MOVE8  = 4'b0110,
        OP_MOVE16 = 4'b0111,
        OP_SHL    = 4'b1000,
        OP_SHR    = 4'b1001,
        OP_ROL    = 4'b1010,
        OP_ROR    = 4'b1011,
        OP_BTST   = 4'b1100,
        OP_DAA    = 4'b1101,
        OP_CLI    = 4'b1110,
        OP_TAP    = 4'b1111
    } ccf_op_t;
    // ----------------------------------------
    // Addressing modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        AM_DIR = 3'b000,
        AM_EXT = 3'b001,
        AM_IX  = 3'b010,
        AM_SP  = 3'b011,
        AM_REL = 3'b100
    } ccf_mode_t;
endpackage

/* File: logic/ccf_flags.sv */
// Contract
// - V set on two's complement overflow
// - Signed branches use the overflow flag
// - H set on carry from bit 3
// - Decimal adjust uses H and C
// - Mask set blocks maskable interrupts
// - Interrupt entry sets mask after stacking
// - No interrupt right after mask clear
// - N follows result bit 7
// - Loads and stores set N from msb
// - Z set for zero result
// - Loads and stores set Z on zero
// - C on add carry or subtract borrow
// - Bit test, shift, rotate update C
// - One linear 16-bit address space
// - Move source and destination modes independent
// - Test-and-branch targets use relative offset
// - Bits 6 and 5 read one
module ccf_flags
    import ccf_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Instruction completion from sequencer
    input  wire logic        opDone,
    input  wire ccf_op_t     opCode,
    input  wire logic [7:0]  opA,
    input  wire logic [7:0]  opB,
    input  wire logic [15:0] opWide,
    output logic      [7:0]  resultOut,
    // Interrupt recognition
    input  wire logic        irqReq,
    input  wire logic        intEntry,
    output logic             irqTake,
    // Branch conditions
    output logic             brGreater,
    output logic             brGreaterEqual,
    output logic             brLessEqual,
    output logic             brLess,
    // Operand addressing
    input  wire ccf_mode_t   srcMode,
    input  wire ccf_mode_t   dstMode,
    input  wire logic [15:0] srcOffset,
    input  wire logic [15:0] dstOffset,
    input  wire logic [15:0] pcValue,
    input  wire logic [15:0] hxValue,
    input  wire logic [15:0] spValue,
    output logic      [15:0] srcAddr,
    output logic      [15:0] dstAddr,
    // Flag register view
    output logic      [7:0]  flagRegister
);
    // ----------------------------------------
    // Effective address in the 64-Kbyte space
    // ----------------------------------------
    function automatic logic [15:0] effAddr(input ccf_mode_t m, input logic [15:0] off);
        logic [15:0] a;
        a = off;
        unique case (m)
            AM_DIR: a = {8'h00, off[7:0]};
            AM_EXT: a = off;
            AM_IX:  a = hxValue + off;
            AM_SP:  a = spValue + off;
            AM_REL: a = pcValue + {{8{off[7]}}, off[7:0]};
            default: a = off;
        endcase
        return a;
    endfunction
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic        shadow_reg;
    logic [7:0]  result_reg;
    logic [7:0]  res;
    logic [4:0]  aff;
    logic        cin;
    logic [8:0]  sum9;
    logic [4:0]  half5;
    logic [7:0]  corr;
    logic        daaCarry;
    logic        wrPend_reg;
    logic [3:0]  wrAddr_reg;
    logic        rdSel;
    logic [15:0] srcAddr_reg;
    logic [15:0] dstAddr_reg;
    // ----------------------------------------
    // Arithmetic flag sources
    // ----------------------------------------
    always_comb
    begin
        cin   = (opCode == OP_ADC || opCode == OP_SBC) ? flags_reg[C_BIT] : 1'b0;
        if (opCode == OP_SUB || opCode == OP_SBC)
            sum9 = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
        else
            sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
        half5 = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        corr  = 8'h00;
        if (flags_reg[H_BIT] || opA[3:0] > BCD_LIMIT)
            corr = corr | DAA_LOW;
        daaCarry = flags_reg[C_BIT] || opA > DAA_HLIMIT;
        if (daaCarry)
            corr = corr | DAA_HIGH;
    end
    // ----------------------------------------
    // Next flags per operation, aff = {V,H,N,Z,C}
    // ----------------------------------------
    always_comb
    begin
        flags_next = flags_reg;
        res        = opA;
        aff        = 5'b00000;
        unique case (opCode)
            OP_ADD, OP_ADC:
            begin
                res = sum9[7:0];
                aff = 5'b11111;
                flags_next[V_BIT] = (opA[7] == opB[7]) && (res[7] != opA[7]);
                flags_next[H_BIT] = half5[4];
                flags_next[C_BIT] = sum9[8];
            end
            OP_SUB, OP_SBC:
            begin
                res = sum9[7:0];
                aff = 5'b10111;
                flags_next[V_BIT] = (opA[7] != opB[7]) && (res[7] != opA[7]);
                flags_next[C_BIT] = sum9[8];
            end
            OP_LOGIC, OP_MOVE8:
            begin
                aff = 5'b10110;
                flags_next[V_BIT] = 1'b0;
            end
            OP_MOVE16:
            begin
                res = opWide[7:0];
                aff = 5'b10110;
                flags_next[V_BIT] = 1'b0;
            end
            OP_SHL, OP_ROL:
            begin
                res = {opA[6:0], (opCode == OP_ROL) ? flags_reg[C_BIT] : 1'b0};
                aff = 5'b10111;
                flags_next[C_BIT] = opA[7];
                flags_next[V_BIT] = res[7] ^ opA[7];
            end
            OP_SHR, OP_ROR:
            begin
                res = {(opCode == OP_ROR) ? flags_reg[C_BIT] : 1'b0, opA[7:1]};
                aff = 5'b10111;
                flags_next[C_BIT] = opA[0];
                flags_next[V_BIT] = res[7] ^ opA[0];
            end
            OP_BTST:
            begin
                aff = 5'b00001;
                flags_next[C_BIT] = opA[opB[2:0]];
            end
            OP_DAA:
            begin
                res = opA + corr;
                aff = 5'b00111;
                flags_next[C_BIT] = daaCarry;
            end
            OP_CLI:
                flags_next[I_BIT] = 1'b0;
            OP_TAP:
                flags_next = opA;
            OP_NONE:
                flags_next = flags_reg;
        endcase
        if (aff[2])
            flags_next[N_BIT] = (opCode == OP_MOVE16) ? opWide[15] : res[7];
        if (aff[1])
            flags_next[Z_BIT] = (opCode == OP_MOVE16) ? (opWide == 16'h0000) : (res == 8'h00);
        flags_next[V_BIT] = aff[4] ? flags_next[V_BIT] : flags_reg[V_BIT];
        flags_next[H_BIT] = aff[3] ? flags_next[H_BIT] : flags_reg[H_BIT];
        flags_next[C_BIT] = aff[0] ? flags_next[C_BIT] : flags_reg[C_BIT];
        if (opCode == OP_TAP)
            flags_next = opA;
        flags_next = flags_next | FIXED_ONES;
    end
    // ----------------------------------------
    // Flag register: entry, completion, bus write
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            flags_reg <= FLAGS_RESET;
        else if (intEntry)
            flags_reg <= flags_reg | (8'h01 << I_BIT);
        else if (opDone)
            flags_reg <= flags_next;
        else if (wrPend_reg && wrAddr_reg == FLAGS_OFFSET)
            flags_reg <= hwdata[7:0] | FIXED_ONES;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            result_reg <= 8'h00;
        else if (opDone)
            result_reg <= res;
    end
    // ----------------------------------------
    // Interrupt recognition
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            shadow_reg <= 1'b0;
        else if (opDone)
            shadow_reg <= flags_reg[I_BIT] && !flags_next[I_BIT];
    end
    assign irqTake = irqReq && opDone && !flags_reg[I_BIT] && !shadow_reg && !intEntry;
    assign brGreaterEqual = !(flags_reg[N_BIT] ^ flags_reg[V_BIT]);
    assign brLess         = flags_reg[N_BIT] ^ flags_reg[V_BIT];
    assign brGreater      = brGreaterEqual && !flags_reg[Z_BIT];
    assign brLessEqual    = brLess || flags_reg[Z_BIT];
    // ----------------------------------------
    // Operand addresses
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            srcAddr_reg <= 16'h0000;
            dstAddr_reg <= 16'h0000;
        end
        else
        begin
            srcAddr_reg <= effAddr(srcMode, srcOffset);
            dstAddr_reg <= effAddr(dstMode, dstOffset);
        end
    end
    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    assign rdSel = hsel && hready && htrans[1] && !hwrite;
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 4'h0;
            hrdata     <= 32'h0000_0000;
        end
        else
        begin
            wrPend_reg <= hsel && hready && htrans[1] && hwrite;
            wrAddr_reg <= haddr[3:0];
            hrdata     <= 32'h0000_0000;
            if (rdSel && haddr[31:4] == 28'h000_0000)
            begin
                if (haddr[3:0] == FLAGS_OFFSET)
                    hrdata <= {24'h00_0000, flags_reg | FIXED_ONES};
                else if (haddr[3:0] == STATUS_OFFSET)
                    hrdata <= {23'h00_0000, shadow_reg, result_reg};
            end
        end
    end
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign resultOut    = result_reg;
    assign srcAddr      = srcAddr_reg;
    assign dstAddr      = dstAddr_reg;
    assign flagRegister = flags_reg | FIXED_ONES;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_ADD_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_ADD && opA == 8'h7F && opB == 8'h01 |=> flags_reg[V_BIT])
        else $error("add overflow not flagged");
    AST_HALF_CARRY: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_ADD |=> flags_reg[H_BIT] == $past(half5[4]))
        else $error("half carry wrong");
    AST_BRANCH_LESS: assert property (@(posedge ref_clk) disable iff (!resetn)
        brLess == (flagRegister[N_BIT] != flagRegister[V_BIT]))
        else $error("signed less wrong");
    AST_MASK_BLOCKS: assert property (@(posedge ref_clk) disable iff (!resetn)
        (flags_reg[I_BIT] || shadow_reg) |-> !irqTake)
        else $error("interrupt taken while masked");
    AST_ENTRY_MASK: assert property (@(posedge ref_clk) disable iff (!resetn)
        intEntry |=> flagRegister[I_BIT])
        else $error("mask not set on entry");
    AST_CLI_SHADOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_CLI && flags_reg[I_BIT] |=> shadow_reg && !flags_reg[I_BIT])
        else $error("interrupt right after mask clear");
    AST_MOVE_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_MOVE16 && opWide == 16'h0000 |=> flags_reg[Z_BIT] && !flags_reg[N_BIT])
        else $error("zero move flags wrong");
    AST_NEG_RESULT: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_LOGIC |=> flags_reg[N_BIT] == $past(opA[7]))
        else $error("negative flag wrong");
    AST_SUB_BORROW: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_SUB && opA < opB |=> flags_reg[C_BIT])
        else $error("borrow not flagged");
    AST_FIXED_ONES: assert property (@(posedge ref_clk) disable iff (!resetn)
        flagRegister[6:5] == 2'b11)
        else $error("fixed bits not one");
    AST_KEEP_FLAGS: assert property (@(posedge ref_clk) disable iff (!resetn)
        opDone && !intEntry && opCode == OP_BTST |=> flags_reg[7:1] == $past(flags_reg[7:1]))
        else $error("unaffected flag changed");
endmodule

/* File: testbench/ccf_seq_model.sv */
module ccf_seq_model
    import ccf_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Instruction completion
    output logic             opDone,
    output ccf_op_t          opCode,
    output logic      [7:0]  opA,
    output logic      [7:0]  opB,
    output logic      [15:0] opWide,
    // Interrupt side
    output logic             irqReq,
    output logic             intEntry,
    input  wire logic        irqTake
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        opDone   = 1'b0;
        opCode   = OP_NONE;
        opA      = 8'h00;
        opB      = 8'h00;
        opWide   = 16'h0000;
        irqReq   = 1'b0;
        intEntry = 1'b0;
    end

    // ----------------------------------------
    // Instruction completion, one cycle pulse
    // ----------------------------------------
    task automatic issue(input ccf_op_t c, input logic [7:0] a, input logic [7:0] b,
                         input logic [15:0] w, output logic took);
        @(posedge ref_clk);
        opDone <= 1'b1;
        opCode <= c;
        opA    <= a;
        opB    <= b;
        opWide <= w;
        @(negedge ref_clk);
        took = irqTake;
        @(posedge ref_clk);
        opDone <= 1'b0;
        // Operands are not held once the op is done
        opA    <= ~a;
        opB    <= ~b;
        opWide <= ~w;
    endtask

    task automatic request(input logic lvl);
        @(posedge ref_clk);
        irqReq <= lvl;
    endtask

    task automatic enter();
        @(posedge ref_clk);
        intEntry <= 1'b1;
        @(posedge ref_clk);
        intEntry <= 1'b0;
    endtask
endmodule

/* File: testbench/ccf_flags_tb.sv */
module ccf_flags_tb
    import ccf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin miscompares++; \
$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [1:0]  htrans  = 2'b00;
    logic [2:0]  hsize   = 3'b010;
    logic [31:0] haddr   = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
    logic        opDone, irqReq, intEntry, irqTake, took;
    ccf_op_t     opCode;
    logic [7:0]  opA, opB, resultOut, flagRegister;
    logic [15:0] opWide, srcAddr, dstAddr;
    logic        brGreater, brGreaterEqual, brLessEqual, brLess;
    ccf_mode_t   srcMode = AM_DIR, dstMode = AM_DIR;
    logic [15:0] srcOffset = 16'h0000, dstOffset = 16'h0000;
    logic [15:0] pcValue = 16'h0000, hxValue = 16'h0000, spValue = 16'h0000;
    int          miscompares = 0, checksDone = 0;

    assign hready = hreadyout;
    always #5 ref_clk = ~ref_clk;

    ccf_flags u_ccf_flags (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp, .opDone, .opCode, .opA, .opB, .opWide, .resultOut, .irqReq,
        .intEntry, .irqTake, .brGreater, .brGreaterEqual, .brLessEqual, .brLess, .srcMode, .dstMode,
        .srcOffset, .dstOffset, .pcValue, .hxValue, .spValue, .srcAddr, .dstAddr, .flagRegister);
    ccf_seq_model u_ccf_seq_model (.ref_clk, .opDone, .opCode, .opA, .opB, .opWide, .irqReq,
        .intEntry, .irqTake);

    // ----------------------------------------
    // Bus and instruction drivers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic op(input ccf_op_t c, input logic [7:0] a, input logic [7:0] b, input logic [15:0] w);
        u_ccf_seq_model.issue(c, a, b, w, took);
        @(negedge ref_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testBus();
        `CHK("flags at reset", 8'h68, flagRegister);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("flags after no-op", FLAGS_RESET, flagRegister);
        bus(1'b1, 32'(FLAGS_OFFSET), 32'h0000_0000);
        bus(1'b0, 32'(FLAGS_OFFSET), 32'h0000_0000);
        `CHK("flags read", 8'h60, r[7:0]);
        `CHK("bus response", 2'b10, {hreadyout, hresp});
        bus(1'b1, 32'h0000_000C, 32'h0000_00FF);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, r);
        bus(1'b0, 32'(FLAGS_OFFSET), 32'h0000_0000);
        `CHK("flags kept", 8'h60, r[7:0]);
        bus(1'b1, 32'(FLAGS_OFFSET), 32'h0000_0068);
        $display("test bus done");
    endtask

    task automatic testArith();
        op(OP_ADD, 8'h7F, 8'h01, 16'h0000);
        `CHK("add overflow", 8'hFC, flagRegister);
        op(OP_ADD, 8'hFF, 8'h01, 16'h0000);
        `CHK("add carry zero", 8'h7B, flagRegister);
        op(OP_SUB, 8'h80, 8'h01, 16'h0000);
        `CHK("sub overflow", 8'hF8, flagRegister);
        `CHK("branch less", 4'b0011, {brGreater, brGreaterEqual, brLessEqual, brLess});
        op(OP_SUB, 8'h00, 8'h01, 16'h0000);
        `CHK("sub borrow", 8'h7D, flagRegister);
        op(OP_SUB, 8'h05, 8'h03, 16'h0000);
        `CHK("sub plain", 8'h78, flagRegister);
        `CHK("branch greater", 4'b1100, {brGreater, brGreaterEqual, brLessEqual, brLess});
        op(OP_ADD, 8'h19, 8'h28, 16'h0000);
        `CHK("add half carry", 8'h78, flagRegister);
        `CHK("add result", 8'h41, resultOut);
        op(OP_ADD, 8'h15, 8'h22, 16'h0000);
        `CHK("add no half carry", 8'h0, flagRegister[H_BIT]);
        op(OP_ADD, 8'h19, 8'h28, 16'h0000);
        op(OP_DAA, 8'h41, 8'h00, 16'h0000);
        `CHK("decimal adjust", 8'h47, resultOut);
        $display("test arith done");
    endtask

    task automatic testMove();
        op(OP_MOVE8, 8'h00, 8'h00, 16'h0000);
        `CHK("load zero", 3'b001, {flagRegister[V_BIT], flagRegister[N_BIT], flagRegister[Z_BIT]});
        op(OP_MOVE16, 8'h00, 8'h00, 16'h8000);
        `CHK("load wide neg", 2'b10, {flagRegister[N_BIT], flagRegister[Z_BIT]});
        op(OP_MOVE16, 8'hFF, 8'h00, 16'h0000);
        `CHK("load wide zero", 2'b01, {flagRegister[N_BIT], flagRegister[Z_BIT]});
        op(OP_SHL, 8'h81, 8'h00, 16'h0000);
        `CHK("shift left carry", 9'h102, {flagRegister[C_BIT], resultOut});
        bus(1'b0, 32'(STATUS_OFFSET), 32'h0000_0000);
        `CHK("status", 9'h002, r[8:0]);
        op(OP_SHR, 8'h01, 8'h00, 16'h0000);
        `CHK("shift right carry", 3'b110, {flagRegister[C_BIT], flagRegister[Z_BIT], flagRegister[N_BIT]});
        $display("test move done");
    endtask

    task automatic testIrq();
        u_ccf_seq_model.request(1'b1);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("masked", 1'b0, took);
        op(OP_CLI, 8'h00, 8'h00, 16'h0000);
        `CHK("mask clear", 8'h60, flagRegister & 8'h68);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("shadow boundary", 1'b0, took);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("taken", 1'b1, took);
        u_ccf_seq_model.enter();
        @(negedge ref_clk);
        `CHK("entry mask", 1'b1, flagRegister[I_BIT]);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("masked again", 1'b0, took);
        $display("test irq done");
    endtask

    task automatic testOps();
        op(OP_TAP, 8'h09, 8'h00, 16'h0000);
        `CHK("transfer flags", 8'h69, flagRegister);
        op(OP_SBC, 8'h10, 8'h0F, 16'h0000);
        `CHK("sbc borrow in", 16'h6A00, {flagRegister, resultOut});
        op(OP_ROL, 8'h80, 8'h00, 16'h0000);
        `CHK("rotate left", 16'hEB00, {flagRegister, resultOut});
        op(OP_ADC, 8'h0E, 8'h01, 16'h0000);
        `CHK("adc half carry", 16'h7810, {flagRegister, resultOut});
        op(OP_BTST, 8'h04, 8'h02, 16'h0000);
        `CHK("bit test carry", 8'h79, flagRegister);
        op(OP_ROR, 8'h02, 8'h00, 16'h0000);
        `CHK("rotate right", 16'hFC81, {flagRegister, resultOut});
        op(OP_LOGIC, 8'h00, 8'h00, 16'h0000);
        `CHK("logic zero", 8'h7A, flagRegister);
        `CHK("branch equal", 4'b0110, {brGreater, brGreaterEqual, brLessEqual, brLess});
        op(OP_TAP, 8'h60, 8'h00, 16'h0000);
        `CHK("transfer unmask", 1'b0, took);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("transfer shadow", 1'b0, took);
        op(OP_NONE, 8'h00, 8'h00, 16'h0000);
        `CHK("taken after transfer", 1'b1, took);
        u_ccf_seq_model.request(1'b0);
        $display("test ops done");
    endtask

    task automatic addr(input ccf_mode_t s, input ccf_mode_t d, input logic [15:0] so, input logic [15:0] dof);
        @(posedge ref_clk);
        srcMode   <= s;
        dstMode   <= d;
        srcOffset <= so;
        dstOffset <= dof;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic testAddr();
        @(posedge ref_clk);
        pcValue <= 16'h1000;
        hxValue <= 16'hFFF0;
        spValue <= 16'h00FF;
        addr(AM_DIR, AM_IX, 16'h12AB, 16'h0020);
        `CHK("direct", 16'h00AB, srcAddr);
        `CHK("indexed wrap", 16'h0010, dstAddr);
        addr(AM_SP, AM_REL, 16'h0001, 16'h00F0);
        `CHK("stack rel", 16'h0100, srcAddr);
        `CHK("relative", 16'h0FF0, dstAddr);
        addr(AM_EXT, AM_REL, 16'hBEEF, 16'h0010);
        `CHK("extended", 16'hBEEF, srcAddr);
        `CHK("relative fwd", 16'h1010, dstAddr);
        $display("test addr done");
    endtask

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        testBus();
        testArith();
        testMove();
        testIrq();
        testOps();
        testAddr();
        reportAndStop();
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        reportAndStop();
    end
endmodule
